// ===== verilog/pbm_regs.svh
// register offsets, field ranges and section table constants of the protect bit map decoder
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PBM_OFF_CFG 8'h00
`define PBM_OFF_TABLE 8'h04
`define PBM_OFF_DECODE 8'h08
`define PBM_OFF_COUNT 8'h0c
`define PBM_OFF_LOOKUP 8'h10

// ----------------------------------------------------------------
// field ranges
// ----------------------------------------------------------------
`define PBM_CFG_M 3:0
`define PBM_CFG_SEL 10:8
`define PBM_CFG_MBIT 23:16
`define PBM_DEC_START 9:0
`define PBM_DEC_END 25:16
`define PBM_CNT_BLOCKS 15:0
`define PBM_CNT_BPB 17:16
`define PBM_CNT_SPAN_OK 31
`define PBM_LK_IDX 9:0
`define PBM_LK_SEC 18:16
`define PBM_LK_HIT 19
`define PBM_LK_RD 20
`define PBM_LK_WR 21
`define PBM_LK_BLK 31:24

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PBM_M_RESET 4'h5
`define PBM_M_MIN 4'h4
`define PBM_M_MAX 4'h8
`define PBM_SEL_RESET 3'h0
`define PBM_LK_RESET 10'h000
`define PBM_NSEC 5
`define PBM_MBIT_BASE 8'h08
`define PBM_HSIZE_WORD 3'h2

// ----------------------------------------------------------------
// section table: sector types, count exponents, adders
// ----------------------------------------------------------------
`define PBM_TYPE_8K 8'h02
`define PBM_TYPE_32K 8'h03
`define PBM_TYPE_64K 8'h04
`define PBM_EXP_8K 8'h02
`define PBM_EXP_32K 8'h00
`define PBM_EXP_NONE 8'h00
`define PBM_EXP_MAX 8'h0f
`define PBM_ADD_BOT_S 8'hff
`define PBM_ADD_BOT_E 8'h06
`define PBM_ADD_LO32 8'hfd
`define PBM_ADD_ZERO 8'h00
`define PBM_ADD_M64_E 8'hfc
`define PBM_ADD_HI32 8'hfe
`define PBM_ADD_TOP_S 8'h07
`define PBM_ADD_TOP_E 8'h0e

`endif

// ===== verilog/pbm_pkg.sv
// types shared by the protect bit map decoder
`default_nettype none
package pbm_pkg;
	typedef logic [9:0] pbm_bit_t;
	typedef enum logic [1:0] {pbm_st_idle, pbm_st_write, pbm_st_read} pbm_bus_e;
endpackage : pbm_pkg
`default_nettype wire

// ===== verilog/pbm_adder_dec.sv
// decodes one start or end adder byte into a protection bit index
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs.svh"
module pbm_adder_dec (
	input wire logic [3:0] m, // density constant
	input wire logic [7:0] adder, // stored adder byte
	output var pbm_pkg::pbm_bit_t bit_idx // decoded bit position
);
	pbm_pkg::pbm_bit_t base;
	pbm_pkg::pbm_bit_t ext;

	// zero points at bit zero, else base plus sign-extended adder
	always_comb begin
		base = (10'h001 << m) + 10'h001;
		ext = {{2{adder[7]}}, adder};
		if (adder == `PBM_ADD_ZERO) begin
			bit_idx = 10'h000;
		end else begin
			bit_idx = base + ext;
		end
	end
endmodule : pbm_adder_dec
`default_nettype wire

// ===== verilog/pbm_count.sv
// block count and protection bits per block of one section
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs.svh"
module pbm_count (
	input wire logic [7:0] sect_type, // sector type code
	input wire logic [7:0] nexp, // number-of-sectors exponent byte
	input wire logic [3:0] m, // density constant
	output logic [15:0] blocks, // blocks in the section
	output logic [1:0] bits_per_blk // protection bits per block
);
	// 64k runs follow the density, others are a power of two, zero for an exponent above 15
	always_comb begin
		if (sect_type == `PBM_TYPE_64K) begin
			blocks = (16'h0001 << m) - 16'h0002;
		end else if (nexp > `PBM_EXP_MAX) begin
			blocks = 16'h0000;
		end else begin
			blocks = 16'h0001 << nexp[3:0];
		end
		bits_per_blk = (sect_type == `PBM_TYPE_8K) ? 2'h2 : 2'h1;
	end
endmodule : pbm_count
`default_nettype wire

// ===== verilog/pbm_decoder.sv
// protect bit map decoder: section table, bit map decode and lookup behind an ahb-lite slave
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs.svh"
module pbm_decoder #(
	parameter logic [3:0] M_RESET = `PBM_M_RESET,
	parameter logic [7:0] BOT_END_ADDER = `PBM_ADD_BOT_E
) (
	input wire logic hclk, // bus clock, 40 mhz
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp // always okay
);
	// ----------------------------------------------------------------
	// elaboration checks and section table
	// ----------------------------------------------------------------
	if (M_RESET < `PBM_M_MIN || M_RESET > `PBM_M_MAX) begin : g_bad_m
		$error("M_RESET outside density range");
	end
	localparam int NSEC = `PBM_NSEC;
	localparam logic [7:0] SEC_TYPE [NSEC] = '{`PBM_TYPE_8K, `PBM_TYPE_32K, `PBM_TYPE_64K, `PBM_TYPE_32K,
		`PBM_TYPE_8K};
	localparam logic [7:0] SEC_EXP [NSEC] = '{`PBM_EXP_8K, `PBM_EXP_32K, `PBM_EXP_NONE, `PBM_EXP_32K, `PBM_EXP_8K};
	localparam logic [7:0] SEC_SADD [NSEC] = '{`PBM_ADD_BOT_S, `PBM_ADD_LO32, `PBM_ADD_ZERO, `PBM_ADD_HI32,
		`PBM_ADD_TOP_S};
	localparam logic [7:0] SEC_EADD [NSEC] = '{BOT_END_ADDER, `PBM_ADD_LO32, `PBM_ADD_M64_E, `PBM_ADD_HI32,
		`PBM_ADD_TOP_E};

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0] m_ff, nxt_m;
	logic [2:0] sel_ff, nxt_sel;
	pbm_pkg::pbm_bit_t lkidx_ff, nxt_lkidx;
	pbm_pkg::pbm_bus_e st_ff, nxt_st;
	logic [7:0] addr_ff, nxt_addr;
	logic size_ok_ff, nxt_size_ok;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hreadyout_ff, nxt_hreadyout;
	logic hresp_ff;
	logic acc;
	logic wr_en;
	logic [31:0] rdata;
	pbm_pkg::pbm_bit_t start_bit [NSEC];
	pbm_pkg::pbm_bit_t end_bit [NSEC];
	logic [7:0] nexp [NSEC];
	logic [15:0] blocks [NSEC];
	logic [1:0] bpb [NSEC];
	pbm_pkg::pbm_bit_t need [NSEC];
	logic [NSEC-1:0] span_ok;
	logic [7:0] mbit;
	logic lk_hit, lk_rd, lk_wr;
	logic [2:0] lk_sec;
	logic [7:0] lk_blk;
	pbm_pkg::pbm_bit_t lk_off;

	// ----------------------------------------------------------------
	// per-section decode
	// ----------------------------------------------------------------
	for (genvar k = 0; k < NSEC; k++) begin : g_sec
		// 64k entries report the density constant in the count byte
		assign nexp[k] = (SEC_TYPE[k] == `PBM_TYPE_64K) ? {4'h0, m_ff} : SEC_EXP[k];
		pbm_adder_dec u_start (
			.m(m_ff),
			.adder(SEC_SADD[k]),
			.bit_idx(start_bit[k])
		);
		pbm_adder_dec u_end (
			.m(m_ff),
			.adder(SEC_EADD[k]),
			.bit_idx(end_bit[k])
		);
		pbm_count u_cnt (
			.sect_type(SEC_TYPE[k]),
			.nexp(nexp[k]),
			.m(m_ff),
			.blocks(blocks[k]),
			.bits_per_blk(bpb[k])
		);
		assign need[k] = (bpb[k] == 2'h2) ? {blocks[k][8:0], 1'b0} : blocks[k][9:0];
		assign span_ok[k] = ((end_bit[k] - start_bit[k]) + 10'h001) == need[k];
	end

	assign mbit = `PBM_MBIT_BASE << (m_ff - `PBM_M_MIN);

	// ----------------------------------------------------------------
	// lookup of one protection bit
	// ----------------------------------------------------------------
	// first section holding the index wins; 8k bits split by parity
	always_comb begin
		lk_hit = 1'b0;
		lk_sec = 3'h0;
		lk_blk = 8'h00;
		lk_rd = 1'b0;
		lk_wr = 1'b0;
		lk_off = 10'h000;
		for (int k = 0; k < NSEC; k++) begin
			if (!lk_hit && lkidx_ff >= start_bit[k] && lkidx_ff <= end_bit[k]) begin
				lk_hit = 1'b1;
				lk_sec = 3'(k);
				lk_off = lkidx_ff - start_bit[k];
				if (bpb[k] == 2'h2) begin
					lk_blk = lk_off[8:1];
					lk_rd = lkidx_ff[0];
					lk_wr = !lkidx_ff[0];
				end else begin
					lk_blk = lk_off[7:0];
					lk_wr = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// table word byte order
	always_comb begin
		rdata = 32'h0000_0000;
		case (addr_ff)
			`PBM_OFF_CFG: begin
				rdata[`PBM_CFG_M] = m_ff;
				rdata[`PBM_CFG_SEL] = sel_ff;
				rdata[`PBM_CFG_MBIT] = mbit;
			end
			`PBM_OFF_TABLE: begin
				rdata = {SEC_EADD[sel_ff], SEC_SADD[sel_ff], nexp[sel_ff], SEC_TYPE[sel_ff]};
			end
			`PBM_OFF_DECODE: begin
				rdata[`PBM_DEC_START] = start_bit[sel_ff];
				rdata[`PBM_DEC_END] = end_bit[sel_ff];
			end
			`PBM_OFF_COUNT: begin
				rdata[`PBM_CNT_BLOCKS] = blocks[sel_ff];
				rdata[`PBM_CNT_BPB] = bpb[sel_ff];
				rdata[`PBM_CNT_SPAN_OK] = span_ok[sel_ff];
			end
			`PBM_OFF_LOOKUP: begin
				rdata[`PBM_LK_IDX] = lkidx_ff;
				rdata[`PBM_LK_SEC] = lk_sec;
				rdata[`PBM_LK_HIT] = lk_hit;
				rdata[`PBM_LK_RD] = lk_rd;
				rdata[`PBM_LK_WR] = lk_wr;
				rdata[`PBM_LK_BLK] = lk_blk;
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	assign acc = hsel && htrans[1] && hready;
	assign wr_en = (st_ff == pbm_pkg::pbm_st_write) && size_ok_ff;

	// bus phases: writes finish at once, reads add one wait state
	always_comb begin
		nxt_st = st_ff;
		nxt_addr = addr_ff;
		nxt_size_ok = size_ok_ff;
		nxt_hrdata = hrdata_ff;
		nxt_hreadyout = 1'b1;
		case (st_ff)
			pbm_pkg::pbm_st_read: begin
				nxt_hrdata = rdata;
				nxt_st = pbm_pkg::pbm_st_idle;
			end
			pbm_pkg::pbm_st_idle, pbm_pkg::pbm_st_write: begin
				nxt_st = pbm_pkg::pbm_st_idle;
				if (acc) begin
					nxt_addr = haddr[7:0];
					nxt_size_ok = (hsize == `PBM_HSIZE_WORD);
					nxt_st = hwrite ? pbm_pkg::pbm_st_write : pbm_pkg::pbm_st_read;
					nxt_hreadyout = hwrite;
				end
			end
			default: begin
				nxt_st = pbm_pkg::pbm_st_idle;
			end
		endcase
	end

	// register writes; out-of-range density or section values are ignored
	always_comb begin
		nxt_m = m_ff;
		nxt_sel = sel_ff;
		nxt_lkidx = lkidx_ff;
		if (wr_en && addr_ff == `PBM_OFF_CFG) begin
			if (hwdata[`PBM_CFG_M] >= `PBM_M_MIN && hwdata[`PBM_CFG_M] <= `PBM_M_MAX) begin
				nxt_m = hwdata[`PBM_CFG_M];
			end
			if (hwdata[`PBM_CFG_SEL] < 3'(NSEC)) begin
				nxt_sel = hwdata[`PBM_CFG_SEL];
			end
		end
		if (wr_en && addr_ff == `PBM_OFF_LOOKUP) begin
			nxt_lkidx = hwdata[`PBM_LK_IDX];
		end
	end

	// flip-flops of all groups
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m_ff <= M_RESET;
			sel_ff <= `PBM_SEL_RESET;
			lkidx_ff <= `PBM_LK_RESET;
			st_ff <= pbm_pkg::pbm_st_idle;
			addr_ff <= `PBM_OFF_CFG;
			size_ok_ff <= 1'b0;
			hrdata_ff <= 32'h0000_0000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end else begin
			m_ff <= nxt_m;
			sel_ff <= nxt_sel;
			lkidx_ff <= nxt_lkidx;
			st_ff <= nxt_st;
			addr_ff <= nxt_addr;
			size_ok_ff <= nxt_size_ok;
			hrdata_ff <= nxt_hrdata;
			hreadyout_ff <= nxt_hreadyout;
			hresp_ff <= 1'b0;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	pbm_pkg::pbm_bit_t pow_m;
	assign pow_m = 10'h001 << m_ff;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_zero_start_bit: assert property (start_bit[2] == 10'h000)
		else $error("64k start is not bit zero");
	a_adder_sum_base: assert property (end_bit[2] == pow_m - 10'h003)
		else $error("64k end is not base plus adder");
	a_span_all_ok: assert property (&span_ok)
		else $error("section span differs from block count");
	a_layout_counts: assert property (blocks[0] == 16'h0004 && blocks[1] == 16'h0001 && blocks[3] == 16'h0001
		&& blocks[4] == 16'h0004)
		else $error("layout block counts wrong");
	a_type_readback: assert property (st_ff == pbm_pkg::pbm_st_read && addr_ff == `PBM_OFF_TABLE |=> hreadyout
		&& hrdata[7:0] == (($past(sel_ff) == 3'h2) ? 8'h04 : ($past(sel_ff) == 3'h1
		|| $past(sel_ff) == 3'h3) ? 8'h03 : 8'h02))
		else $error("sector type code wrong");
	a_pow_count: assert property (blocks[1] == 16'h0001 && blocks[0] == 16'h0004)
		else $error("8k or 32k count wrong");
	a_count_64k: assert property (blocks[2] == (16'h0001 << m_ff) - 16'h0002)
		else $error("64k count wrong");
	a_density_range: assert property (m_ff >= 4'h4 && m_ff <= 4'h8 && mbit == (8'h08 << (m_ff - 4'h4)))
		else $error("density constant out of range");
	a_neg_adder: assert property (start_bit[0] < pow_m + 10'h001 && start_bit[3] < pow_m + 10'h001)
		else $error("negative adder not below base");
	a_bottom_8k: assert property (start_bit[0] == pow_m && end_bit[0] == pow_m + 10'h007)
		else $error("bottom 8k bits wrong");
	a_lower_32k: assert property (start_bit[1] == end_bit[1] && start_bit[1] == pow_m - 10'h002)
		else $error("lower 32k bit wrong");
	a_run_64k: assert property (end_bit[2] + 10'h001 == blocks[2][9:0])
		else $error("64k run does not end at its count");
	a_upper_32k: assert property (start_bit[3] == end_bit[3] && start_bit[3] == pow_m - 10'h001)
		else $error("upper 32k bit wrong");
	a_top_8k: assert property (start_bit[4] == pow_m + 10'h008 && end_bit[4] == pow_m + 10'h00f)
		else $error("top 8k bits wrong");
	a_parity_lock: assert property (lk_hit && (lk_sec == 3'h0 || lk_sec == 3'h4) |-> lk_rd == lkidx_ff[0]
		&& lk_wr == !lkidx_ff[0])
		else $error("8k lock parity wrong");
	a_table_order: assert property (st_ff == pbm_pkg::pbm_st_read && addr_ff == `PBM_OFF_TABLE |=> hrdata[23:16]
		== SEC_SADD[$past(sel_ff)] && hrdata[31:24] == SEC_EADD[$past(sel_ff)])
		else $error("table word field order wrong");
	a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_cfg_write: cover property (wr_en && addr_ff == `PBM_OFF_CFG);
	c_table_read: cover property (st_ff == pbm_pkg::pbm_st_read && addr_ff == `PBM_OFF_TABLE);
	c_read_lock_hit: cover property (lk_hit && lk_rd);
	c_lookup_miss: cover property (!lk_hit && wr_en && addr_ff == `PBM_OFF_LOOKUP);
endmodule : pbm_decoder
`default_nettype wire

// ===== sim/pbm_host_model.sv
// host side bus master model that reads the protect bit map decoder over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module pbm_host_model (
	input wire logic hclk, // bus clock
	input wire logic hready, // bus ready, sampled at rising edge
	input wire logic [31:0] hrdata, // read data from the slave
	output logic hsel, // slave select
	output logic [31:0] haddr, // byte address
	output logic [1:0] htrans, // transfer type
	output logic hwrite, // write when high
	output logic [2:0] hsize, // transfer size
	output logic [31:0] hwdata // write data
);
	// ----------------------------------------------------------------
	// idle bus and address phase
	// ----------------------------------------------------------------
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// present one nonseq address phase and hold it until hready is seen high
	task automatic addr_ph(input logic [7:0] a, input logic w, input logic [2:0] sz);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= sz;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		haddr <= ~{24'h0, a}; // released address no longer shows the old value
	endtask : addr_ph

	// single word write, sized write for refusal tests
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
		addr_ph(a, 1'b1, sz);
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		hwdata <= ~d; // released data line flips
	endtask : wr

	// single word read, data taken at the edge where hready is high
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr_ph(a, 1'b0, 3'h2);
		do @(posedge hclk); while (hready !== 1'b1);
		d = hrdata;
	endtask : rd

	// ----------------------------------------------------------------
	// host side decode of a stored adder byte
	// ----------------------------------------------------------------
	// sign-extend nonzero adder
	function automatic logic [9:0] bit_of(input logic [3:0] m, input logic [7:0] c);
		logic [9:0] base;
		base = 10'h001 << m;
		bit_of = (c === 8'h00) ? 10'h000 : base + 10'h001 + {{2{c[7]}}, c};
	endfunction : bit_of
endmodule : pbm_host_model
`default_nettype wire

// ===== sim/protect_bit_map_decoder_tb.sv
// self-checking testbench of the protect bit map decoder
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs.svh"
module protect_bit_map_decoder_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	wire logic hsel, hwrite, hready, hresp;
	wire logic hreadyout;
	wire logic [31:0] haddr, hwdata, hrdata;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize;
	int fail_count = 0;
	int n_compared = 0;
	logic [31:0] d;
	// expected section table, bottom to top
	logic [7:0] e_ty [5] = '{8'h02, 8'h03, 8'h04, 8'h03, 8'h02};
	logic [7:0] e_n [5] = '{8'h02, 8'h00, 8'h05, 8'h00, 8'h02};
	logic [7:0] e_s [5] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
	logic [7:0] e_e [5] = '{8'h06, 8'hfd, 8'hfc, 8'hfe, 8'h0e};

	// ----------------------------------------------------------------
	// clock, design and host
	// ----------------------------------------------------------------
	// 40 mhz bus clock
	always #12.5 hclk = ~hclk;
	assign hready = hreadyout;

	pbm_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	pbm_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	// compare one value and count it
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	// config word as read back, with the read-only density in megabit
	function automatic logic [31:0] cfg_exp(input logic [3:0] m, input logic [2:0] s);
		cfg_exp = {8'h00, 8'h08 << (m - 4'h4), 5'h00, s, 4'h0, m};
	endfunction : cfg_exp

	// print counts and verdict, then end the run
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values of the config register and okay response
	task automatic t_reset();
		host.rd(`PBM_OFF_CFG, d);
		chk("cfg after reset", cfg_exp(4'h5, 3'h0), d);
		chk("hresp", 32'h0, {31'h0, hresp});
		$display("test reset done");
	endtask : t_reset

	// every section at m=5: fields, decoded bits, counts and span
	task automatic t_sections();
		logic [15:0] blk;
		logic [1:0] bpb;
		for (int s = 0; s < 5; s++) begin
			host.wr(`PBM_OFF_CFG, {21'h0, s[2:0], 4'h0, 4'h5});
			host.rd(`PBM_OFF_TABLE, d);
			chk("table", {e_e[s], e_s[s], e_n[s], e_ty[s]}, d);
			host.rd(`PBM_OFF_DECODE, d);
			chk("decode", {6'h0, host.bit_of(4'h5, e_e[s]), 6'h0, host.bit_of(4'h5, e_s[s])}, d);
			blk = (s == 2) ? 16'd30 : 16'h0001 << e_n[s];
			bpb = (e_ty[s] == 8'h02) ? 2'd2 : 2'd1;
			host.rd(`PBM_OFF_COUNT, d);
			chk("count", {1'b1, 13'h0, bpb, blk}, d);
		end
		$display("test sections done");
	endtask : t_sections

	// every density constant: megabit, 64k count and end bit
	task automatic t_density();
		logic [3:0] m;
		for (int i = 4; i <= 8; i++) begin
			m = i[3:0];
			host.wr(`PBM_OFF_CFG, {21'h0, 3'h2, 4'h0, m});
			host.rd(`PBM_OFF_CFG, d);
			chk("cfg density", cfg_exp(m, 3'h2), d);
			host.rd(`PBM_OFF_TABLE, d);
			chk("table 64k", {8'hfc, 8'h00, 4'h0, m, 8'h04}, d);
			host.rd(`PBM_OFF_DECODE, d);
			chk("decode 64k", {6'h0, (10'h001 << m) - 10'h003, 16'h0000}, d);
			host.rd(`PBM_OFF_COUNT, d);
			chk("count 64k", {1'b1, 13'h0, 2'd1, (16'h0001 << m) - 16'h0002}, d);
		end
		$display("test density done");
	endtask : t_density

	// refused config values, byte writes and unmapped offsets
	task automatic t_refuse();
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h4, 4'h0, 4'h5});
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h4, 4'h0, 4'h3});
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h4, 4'h0, 4'h9});
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h5, 4'h0, 4'h6});
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h0, 4'h0, 4'h7}, 3'h0);
		host.rd(`PBM_OFF_CFG, d);
		chk("cfg refused", cfg_exp(4'h6, 3'h4), d);
		host.wr(8'h20, 32'hffff_ffff);
		host.rd(8'h20, d);
		chk("unmapped", 32'h0, d);
		$display("test refuse done");
	endtask : t_refuse

	// lookup of bit positions: section, lock kind, block number, miss
	task automatic t_lookup();
		logic [9:0] ix [8] = '{10'd32, 10'd39, 10'd30, 10'd29, 10'd31, 10'd40, 10'd47, 10'd48};
		logic [2:0] sc [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0};
		logic [7:0] bk [8] = '{8'h00, 8'h03, 8'h00, 8'h1d, 8'h00, 8'h00, 8'h03, 8'h00};
		logic [3:0] fl [8] = '{4'h5, 4'h3, 4'h5, 4'h5, 4'h5, 4'h5, 4'h3, 4'h0};
		host.wr(`PBM_OFF_CFG, {21'h0, 3'h0, 4'h0, 4'h5});
		for (int k = 0; k < 8; k++) begin
			host.wr(`PBM_OFF_LOOKUP, {22'h0, ix[k]});
			host.rd(`PBM_OFF_LOOKUP, d);
			chk("lookup", {bk[k], 2'h0, fl[k][2:0], sc[k], 6'h0, ix[k]}, d);
		end
		$display("test lookup done");
	endtask : t_lookup

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	// reset for three cycles, then run the scenarios
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_sections();
		t_density();
		t_refuse();
		t_lookup();
		stop_test();
	end

	// cut a hang short after 5000 cycles, well past the two hundred or so cycles the scenarios need
	initial begin
		#(25 * 5000);
		fail_count++;
		stop_test();
	end
endmodule : protect_bit_map_decoder_tb
`default_nettype wire
